// ### design/lsp_host_port.sv
// Processor parameter port of the speech analysis/synthesis device
//
// Contract
// - Selected only while strobe high and select_n low.
// - Writes: 0 control, 1 slot selector, 2/3 input register with A0 LSB.
// - Reads: 0 status, 1 none, 2 output register, 3 also fetch.
// - Coefficient writes capture nine bits, A0 as LSB.
// - Input write sets busy; stored when slot passes; busy clears.
// - Parameters rotate in rings; one bit-serial access point per period.
// - Fetch sets busy; copies slot truncated to eight bits; busy clears.
// - Busy flag visible in status register.
// - Wait pulled low for codes 1,2,3,7 while busy and selected.
// - Low reset holds device; runs after reset returns high.
// - Clock pin: external test clock input or divided clock output.
// - Speech output as eight-bit pulse-width modulation.
// - Three gain-select outputs for external amplifier.
// - Converter clock toggles only while converter enabled, else low.
// - Active-low converter enable; serial converter data input.
// - Active-low open-drain interrupt request output.
// - Ten nine-bit coefficients; index 0 is first filter section.
// - Excitation low bits pick eight of sixteen filter output bits.
// - Selector bits 0-3 index the parameter per mode.
// - Selector bit 5 picks the buffer; host writes keep it, sequence sets it only for recognition SR.
// - Busy is status bit 7; fetch overwrites output register.
// - Selector advances through mode sequence after each transfer.
`timescale 1ns/1ps
`default_nettype none
module lsp_host_port import lsp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Processor bus pins
    input wire logic strobe,
    input wire logic select_n,
    input wire logic rw,
    input wire logic [1:0] addr,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe,
    output logic wait_n_o,
    output logic wait_n_oe,
    // Interrupt
    input wire logic irq_req,
    output logic irq_n_o,
    output logic irq_n_oe,
    // Clock pin
    input wire logic clock_pin_i,
    output logic clock_pin_o,
    output logic clock_pin_oe,
    // Speech and gain
    input wire logic [15:0] filter_sample,
    input wire logic [2:0] agc_gain,
    output logic digital_out,
    output logic gain_6,
    output logic gain_12,
    output logic gain_24,
    // Converter
    input wire logic conv_data_in,
    output logic conv_clk_out,
    output logic conv_enable_n,
    output logic [7:0] conv_sample
);
    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic rst_s1_reg, rst_n;
    logic [14:0] pin_s1_reg, pin_s2_reg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {strobe, select_n, rw, addr, data_i,
                           conv_data_in, clock_pin_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end
    logic sel_s, rw_s, cdat_s, ck_s;
    logic [1:0] a_s;
    logic [7:0] d_s;
    assign sel_s = pin_s2_reg[14] & ~pin_s2_reg[13];
    assign rw_s = pin_s2_reg[12];
    assign a_s = pin_s2_reg[11:10];
    assign d_s = pin_s2_reg[9:2];
    assign cdat_s = pin_s2_reg[1];
    assign ck_s = pin_s2_reg[0];

    // ----------------------------------------
    // Bus state and transfer engine
    // ----------------------------------------
    lsp_xfer_type st_reg, st_next;
    logic sel_d_reg, sel_d_next, op_rw_reg, op_rw_next, is_wr_reg, is_wr_next;
    logic [1:0] op_a_reg, op_a_next;
    logic [7:0] op_d_reg, op_d_next, ctrl_reg, ctrl_next;
    logic [7:0] param_slot_select_reg, param_slot_select_next;
    logic [7:0] dout_reg, dout_next, data_o_next;
    logic [8:0] din_reg, din_next, acc_reg, acc_next;
    logic [2:0] exc_reg, exc_next;
    logic [3:0] slot_reg, slot_next, bit_reg, bit_next;
    logic ck_d_reg, shift_en, trail, busy, on_bit, done, ring_rd;
    logic [3:0] idx;

    lsp_ring_if rif0 ();
    lsp_ring_if rif1 ();
    lsp_param_ring u_ring0 (.clk(clk), .rst_n(rst_n), .rif(rif0.ring));
    lsp_param_ring u_ring1 (.clk(clk), .rst_n(rst_n), .rif(rif1.ring));

    assign idx = param_slot_select_reg[3:0];
    assign busy = (st_reg != PX_IDLE);
    assign trail = sel_d_reg & ~sel_s;
    assign shift_en = ctrl_reg[CTL_TCLK] ? (ck_s & ~ck_d_reg) : 1'b1;
    assign ring_rd = param_slot_select_reg[SEL_BUF] ? rif1.rd_bit
                                                    : rif0.rd_bit;
    assign on_bit = busy && shift_en && (slot_reg == idx)
                    && (st_reg == PX_MOVE || bit_reg == 4'h0);
    assign done = on_bit && (bit_reg == BIT_LAST);
    assign rif0.shift_en = shift_en;
    assign rif1.shift_en = shift_en;
    assign rif0.wr_en = on_bit & is_wr_reg & ~param_slot_select_reg[SEL_BUF];
    assign rif1.wr_en = on_bit & is_wr_reg & param_slot_select_reg[SEL_BUF];
    assign rif0.wr_bit = din_reg[bit_reg];
    assign rif1.wr_bit = din_reg[bit_reg];

    function automatic logic [7:0] next_slot(input logic [7:0] s,
                                             input logic syn);
        logic [3:0] i;
        i = s[3:0];
        if (syn) begin
            next_slot = (i == SYN_LAST) ? 8'h00 : {4'h0, i + 4'h1};
        end else if (s[SEL_BUF] || i >= REC_SR) begin
            next_slot = 8'h00;
        end else if (i == REC_T2) begin
            next_slot = 8'h20 | {4'h0, REC_SR};
        end else begin
            next_slot = {4'h0, i + 4'h1};
        end
    endfunction : next_slot

    always_comb begin
        sel_d_next = sel_s;
        op_rw_next = op_rw_reg;
        op_a_next = op_a_reg;
        op_d_next = op_d_reg;
        if (sel_s) begin
            op_rw_next = rw_s;
            op_a_next = a_s;
            op_d_next = d_s;
        end
        st_next = st_reg;
        is_wr_next = is_wr_reg;
        ctrl_next = ctrl_reg;
        param_slot_select_next = param_slot_select_reg;
        din_next = din_reg;
        dout_next = dout_reg;
        acc_next = acc_reg;
        exc_next = exc_reg;
        if (shift_en) begin
            bit_next = (bit_reg == BIT_LAST) ? 4'h0 : bit_reg + 4'h1;
            slot_next = (bit_reg == BIT_LAST) ? slot_reg + 4'h1 : slot_reg;
        end else begin
            bit_next = bit_reg;
            slot_next = slot_reg;
        end
        if (on_bit) begin
            acc_next[bit_reg] = ring_rd;
            st_next = PX_MOVE;
        end
        if (done) begin
            st_next = PX_IDLE;
            if (!is_wr_reg) begin
                dout_next = {ring_rd, acc_reg[7:1]};
            end else if (ctrl_reg[CTL_SYN] && idx == IDX_EXC
                         && !param_slot_select_reg[SEL_BUF]) begin
                exc_next = din_reg[3:1];
            end
            param_slot_select_next = next_slot(param_slot_select_reg,
                                               ctrl_reg[CTL_SYN]);
        end
        if (trail && !op_rw_reg) begin
            if (op_a_reg == OP_CTRL) begin
                ctrl_next = op_d_reg;
            end else if (!busy && op_a_reg == OP_ADDR) begin
                param_slot_select_next = op_d_reg & 8'h2f;
            end else if (!busy) begin
                din_next = {op_d_reg, op_a_reg[0]};
                st_next = PX_WAIT;
                is_wr_next = 1'b1;
            end
        end else if (trail && !busy && op_a_reg == OP_FETCH) begin
            st_next = PX_WAIT;
            is_wr_next = 1'b0;
        end
        case (a_s)
            OP_STAT: data_o_next = {busy, ctrl_reg[CTL_SYN], 2'h0,
                                    slot_reg == idx, 3'h0};
            OP_DOUT, OP_FETCH: data_o_next = dout_reg;
            default: data_o_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= PX_IDLE;
            sel_d_reg <= 1'b0;
            op_rw_reg <= 1'b0;
            op_a_reg <= 2'h0;
            op_d_reg <= 8'h00;
            is_wr_reg <= 1'b0;
            ctrl_reg <= CTRL_RST;
            param_slot_select_reg <= SEL_RST;
            din_reg <= '0;
            dout_reg <= 8'h00;
            acc_reg <= '0;
            exc_reg <= 3'h0;
            slot_reg <= 4'h0;
            bit_reg <= 4'h0;
            ck_d_reg <= 1'b0;
            data_o <= 8'h00;
        end else begin
            st_reg <= st_next;
            sel_d_reg <= sel_d_next;
            op_rw_reg <= op_rw_next;
            op_a_reg <= op_a_next;
            op_d_reg <= op_d_next;
            is_wr_reg <= is_wr_next;
            ctrl_reg <= ctrl_next;
            param_slot_select_reg <= param_slot_select_next;
            din_reg <= din_next;
            dout_reg <= dout_next;
            acc_reg <= acc_next;
            exc_reg <= exc_next;
            slot_reg <= slot_next;
            bit_reg <= bit_next;
            ck_d_reg <= ck_s;
            data_o <= data_o_next;
        end
    end

    assign data_oe = sel_s & rw_s;
    assign wait_n_o = 1'b0;
    assign wait_n_oe = sel_s & busy & (rw_s ? (a_s == OP_FETCH)
                                            : (a_s != OP_CTRL));
    assign irq_n_o = 1'b0;
    assign irq_n_oe = irq_req;

    // ----------------------------------------
    // Clock pin, PWM output, gain outputs
    // ----------------------------------------
    logic ckout_reg, dig_reg, dig_next;
    logic [7:0] pwm_cnt_reg, pwm_lvl_reg, pwm_lvl_next;
    logic [2:0] gain_reg;
    logic [19:0] ext;
    logic [19:0] win;
    assign ext = {{4{filter_sample[15]}}, filter_sample};
    assign win = ext >> (5'd12 - {2'b00, exc_reg});
    always_comb begin
        pwm_lvl_next = (pwm_cnt_reg == 8'hff) ? (win[7:0] ^ 8'h80)
                                              : pwm_lvl_reg;
        dig_next = ctrl_reg[CTL_TINT] ? rif0.rd_bit
                                      : (pwm_cnt_reg < pwm_lvl_reg);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ckout_reg <= 1'b0;
            pwm_cnt_reg <= 8'h00;
            pwm_lvl_reg <= 8'h80;
            dig_reg <= 1'b0;
            gain_reg <= 3'h0;
        end else begin
            ckout_reg <= ~ckout_reg;
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
            pwm_lvl_reg <= pwm_lvl_next;
            dig_reg <= dig_next;
            gain_reg <= agc_gain;
        end
    end
    assign clock_pin_o = ckout_reg;
    assign clock_pin_oe = ~ctrl_reg[CTL_TCLK];
    assign digital_out = dig_reg;
    assign {gain_24, gain_12, gain_6} = gain_reg;

    // ----------------------------------------
    // Serial converter control
    // ----------------------------------------
    logic conv_on_reg, conv_on_next, cclk_reg, cclk_next;
    logic [5:0] div_reg, div_next;
    logic [3:0] nbit_reg, nbit_next;
    logic [7:0] csh_reg, csh_next, csmp_next;
    always_comb begin
        conv_on_next = conv_on_reg;
        cclk_next = cclk_reg;
        div_next = div_reg;
        nbit_next = nbit_reg;
        csh_next = csh_reg;
        csmp_next = conv_sample;
        if (!conv_on_reg) begin
            if (!ctrl_reg[CTL_SYN] && shift_en && slot_reg == 4'h0
                && bit_reg == 4'h0) begin
                conv_on_next = 1'b1;
                div_next = 6'h00;
                nbit_next = 4'h0;
            end
        end else if (div_reg == CONV_HALF_M1) begin
            div_next = 6'h00;
            cclk_next = ~cclk_reg;
            if (!cclk_reg) begin
                csh_next = {csh_reg[6:0], cdat_s};
                nbit_next = nbit_reg + 4'h1;
            end else if (nbit_reg == CONV_BITS) begin
                conv_on_next = 1'b0;
                csmp_next = csh_reg;
            end
        end else begin
            div_next = div_reg + 6'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_on_reg <= 1'b0;
            cclk_reg <= 1'b0;
            div_reg <= 6'h00;
            nbit_reg <= 4'h0;
            csh_reg <= 8'h00;
            conv_sample <= 8'h00;
        end else begin
            conv_on_reg <= conv_on_next;
            cclk_reg <= cclk_next;
            div_reg <= div_next;
            nbit_reg <= nbit_next;
            csh_reg <= csh_next;
            conv_sample <= csmp_next;
        end
    end
    assign conv_clk_out = cclk_reg;
    assign conv_enable_n = ~conv_on_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_desel;
        !sel_s |-> !data_oe && !wait_n_oe;
    endproperty
    a_desel: assert property (p_desel) else $error("bus active");
    property p_ctrl_wr;
        trail && !op_rw_reg && op_a_reg == OP_CTRL
            |=> ctrl_reg == $past(op_d_reg);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl lost");
    property p_din;
        trail && !op_rw_reg && op_a_reg[1] && !busy
            |=> busy && din_reg == {$past(op_d_reg), $past(op_a_reg[0])};
    endproperty
    a_din: assert property (p_din) else $error("din wrong");
    property p_fetch_end;
        trail && op_rw_reg && op_a_reg == OP_FETCH && !busy
            && !ctrl_reg[CTL_TCLK] |=> busy ##[1:300] !busy;
    endproperty
    a_fetch_end: assert property (p_fetch_end) else $error("stuck");
    property p_fetch_val;
        done && !is_wr_reg |=> dout_reg == {$past(ring_rd), $past(acc_reg[7:1])};
    endproperty
    a_fetch_val: assert property (p_fetch_val) else $error("dout");
    property p_store_end;
        done && is_wr_reg |=> !busy;
    endproperty
    a_store_end: assert property (p_store_end) else $error("busy");
    property p_status;
        sel_s && rw_s && a_s == OP_STAT |=> data_o[STS_BUSY] == $past(busy);
    endproperty
    a_status: assert property (p_status) else $error("status");
    property p_wait;
        sel_s && busy && !rw_s && a_s == OP_ADDR |-> wait_n_oe;
    endproperty
    a_wait: assert property (p_wait) else $error("no wait");
    property p_cclk;
        conv_enable_n |-> !conv_clk_out;
    endproperty
    a_cclk: assert property (p_cclk) else $error("conv clk");
    property p_adv;
        done |=> param_slot_select_reg != $past(param_slot_select_reg);
    endproperty
    a_adv: assert property (p_adv) else $error("no advance");
    c_fetch: cover property (done && !is_wr_reg);
    c_store: cover property (done && is_wr_reg);
    c_wait: cover property (wait_n_oe);
    c_conv: cover property ($fell(conv_enable_n));
endmodule : lsp_host_port
`default_nettype wire

// ### design/lsp_param_ring.sv
// Recirculating bit-serial parameter ring
`timescale 1ns/1ps
`default_nettype none
module lsp_param_ring import lsp_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Access point
    lsp_ring_if.ring rif
);
    logic [RING_LEN-1:0] ring_reg;
    logic [RING_LEN-1:0] ring_next;

    // ----------------------------------------
    // Rotate, replacing the bit at the access point on writes
    // ----------------------------------------
    always_comb begin
        ring_next = ring_reg;
        if (rif.shift_en) begin
            ring_next = {(rif.wr_en ? rif.wr_bit : ring_reg[0]),
                         ring_reg[RING_LEN-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ring_reg <= '0;
        end else begin
            ring_reg <= ring_next;
        end
    end

    assign rif.rd_bit = ring_reg[0];
endmodule : lsp_param_ring
`default_nettype wire

// ### design/lsp_pkg.sv
// Shared constants and types for the speech parameter host port
package lsp_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_HZ = 150_000;
    localparam int CONV_HALF = CLK_HZ / (2 * CONV_HZ);
    localparam logic [5:0] CONV_HALF_M1 = 6'(CONV_HALF - 1);
    localparam logic [3:0] CONV_BITS = 4'h8;
    // ----------------------------------------
    // Parameter rings
    // ----------------------------------------
    localparam int SLOTS = 16;
    localparam int PW = 9;
    localparam int RING_LEN = SLOTS * PW;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] SLOT_LAST = 4'hf;
    // ----------------------------------------
    // Operation codes, address lines
    // ----------------------------------------
    localparam logic [1:0] OP_CTRL = 2'h0;
    localparam logic [1:0] OP_ADDR = 2'h1;
    localparam logic [1:0] OP_STAT = 2'h0;
    localparam logic [1:0] OP_DOUT = 2'h2;
    localparam logic [1:0] OP_FETCH = 2'h3;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CTL_SYN = 6;
    localparam int CTL_TINT = 1;
    localparam int CTL_TCLK = 0;
    localparam int STS_BUSY = 7;
    localparam int STS_SYN = 6;
    localparam int STS_COINC = 3;
    localparam int SEL_BUF = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [3:0] IDX_EXC = 4'ha;
    localparam logic [3:0] SYN_LAST = 4'he;
    localparam logic [3:0] REC_T2 = 4'ha;
    localparam logic [3:0] REC_SR = 4'hb;
    // ----------------------------------------
    // Transfer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        PX_IDLE = 2'b00,
        PX_WAIT = 2'b01,
        PX_MOVE = 2'b10
    } lsp_xfer_type;
endpackage : lsp_pkg

// ### design/lsp_ring_if.sv
// Access point signals of one parameter ring
`timescale 1ns/1ps
`default_nettype none
interface lsp_ring_if;
    logic shift_en;
    logic wr_en;
    logic wr_bit;
    logic rd_bit;
    modport ctl (output shift_en, output wr_en, output wr_bit, input rd_bit);
    modport ring (input shift_en, input wr_en, input wr_bit, output rd_bit);
endinterface : lsp_ring_if
`default_nettype wire

// ### sim/lsp_host_model.sv
// Processor bus master model for the speech parameter host port
`timescale 1ns/1ps
`default_nettype none
module lsp_host_model import lsp_pkg::*; (
    // Clock
    input wire logic clk,
    // Bus pins
    output logic strobe,
    output logic select_n,
    output logic rw,
    output logic [1:0] addr,
    output wire logic [7:0] data_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe,
    input wire logic wait_n_oe
);
    logic drv = 1'b0;
    logic [7:0] wd = 8'h00;
    logic [7:0] last = 8'h00;
    initial begin
        strobe = 1'b0;
        select_n = 1'b1;
        rw = 1'b1;
        addr = 2'h0;
    end
    // Shared data lines; released lines show the inverse of the last value
    assign data_i = drv ? wd : (data_oe ? data_o : ~last);
    always @(negedge clk) begin
        if (drv || data_oe) begin
            last <= data_i;
        end
    end
    // One bus cycle: code is {rw, a1, a0}; stb low leaves chip unselected
    task automatic access(input logic stb, input logic [2:0] code,
        input logic [7:0] d, output logic [7:0] q, output logic [1:0] f);
        @(negedge clk);
        rw = code[2];
        addr = code[1:0];
        wd = d;
        drv = ~code[2];
        strobe = stb;
        select_n = 1'b0;
        repeat (5) @(negedge clk);
        q = data_i;
        f = {data_oe, wait_n_oe};
        strobe = 1'b0;
        select_n = 1'b1;
        drv = 1'b0;
        repeat (3) @(negedge clk);
    endtask : access
    // Poll status until busy drops
    task automatic wait_idle(output logic ok);
        logic [7:0] q;
        logic [1:0] f;
        ok = 1'b0;
        for (int i = 0; i < 60 && !ok; i++) begin
            access(1'b1, 3'h4, 8'h00, q, f);
            ok = (q[STS_BUSY] === 1'b0);
        end
    endtask : wait_idle
endmodule : lsp_host_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking testbench for the speech parameter host port
`timescale 1ns/1ps
`default_nettype none
module tb import lsp_pkg::*; ();
    logic clk;
    logic resetn = 1'b0;
    logic strobe, select_n, rw;
    logic [1:0] addr;
    logic [7:0] data_i, data_o;
    logic data_oe, wait_n_oe, irq_n_oe, clock_pin_oe;
    logic irq_req = 1'b0;
    logic clock_pin_i = 1'b0;
    logic [15:0] filter_sample = 16'h0000;
    logic [2:0] agc_gain = 3'h0;
    logic gain_6, gain_12, gain_24;
    logic wait_n_o, irq_n_o, clock_pin_o, digital_out;
    logic conv_data_in;
    logic tclk_run = 1'b0;
    logic conv_clk_out, conv_enable_n;
    logic [7:0] conv_sample;
    int errors = 0;
    int num_checks = 0;

    lsp_host_port dut (.clk(clk), .resetn(resetn), .strobe(strobe),
        .select_n(select_n), .rw(rw), .addr(addr), .data_i(data_i),
        .data_o(data_o), .data_oe(data_oe), .wait_n_o(wait_n_o),
        .wait_n_oe(wait_n_oe), .irq_req(irq_req), .irq_n_o(irq_n_o),
        .irq_n_oe(irq_n_oe), .clock_pin_i(clock_pin_i),
        .clock_pin_o(clock_pin_o), .clock_pin_oe(clock_pin_oe),
        .filter_sample(filter_sample), .agc_gain(agc_gain),
        .digital_out(digital_out), .gain_6(gain_6),
        .gain_12(gain_12), .gain_24(gain_24), .conv_data_in(conv_data_in),
        .conv_clk_out(conv_clk_out), .conv_enable_n(conv_enable_n),
        .conv_sample(conv_sample));

    lsp_host_model host (.clk(clk), .strobe(strobe), .select_n(select_n),
        .rw(rw), .addr(addr), .data_i(data_i), .data_o(data_o),
        .data_oe(data_oe), .wait_n_oe(wait_n_oe));

    // ----------------------------------------
    // Converter model and test clock source
    // ----------------------------------------
    logic [7:0] conv_byte = 8'h00;
    logic [7:0] conv_shift = 8'h00;
    logic conv_clk_d = 1'b0;
    assign conv_data_in = conv_shift[7];
    always @(negedge clk) begin
        conv_clk_d <= conv_clk_out;
        if (conv_enable_n) begin
            conv_shift <= conv_byte;
        end else if (conv_clk_d && !conv_clk_out) begin
            conv_shift <= {conv_shift[6:0], 1'b0};
        end
        if (tclk_run) begin
            clock_pin_i <= ~clock_pin_i;
        end
    end

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic s_decode;
        logic [7:0] q;
        logic [1:0] f;
        host.access(1'b0, 3'h0, 8'h40, q, f);
        host.access(1'b0, 3'h4, 8'h00, q, f);
        check(f, 2'h0);
        host.access(1'b1, 3'h4, 8'h00, q, f);
        check(q & 8'h40, 8'h00);
        check(f[1], 1'b1);
        host.access(1'b1, 3'h5, 8'h00, q, f);
        check(q, 8'h00);
        host.access(1'b1, 3'h0, 8'h00, q, f);
        check(f[1], 1'b0);
    endtask : s_decode

    task automatic s_xfer;
        logic [7:0] q;
        logic [1:0] f;
        logic [2:0] c;
        logic ok;
        host.access(1'b1, 3'h0, 8'h41, q, f);
        check(clock_pin_oe, 1'b0);
        host.access(1'b1, 3'h1, 8'h03, q, f);
        host.access(1'b1, 3'h3, 8'ha5, q, f);
        host.access(1'b1, 3'h4, 8'h00, q, f);
        check(q & 8'hc0, 8'hc0);
        for (int i = 0; i < 4; i++) begin
            c = (i == 3) ? 3'h7 : 3'(i + 1);
            host.access(1'b1, c, 8'h07, q, f);
            check(f[0], 1'b1);
            check(wait_n_oe, 1'b0);
            check(wait_n_o, 1'b0);
        end
        tclk_run = 1'b1;
        host.wait_idle(ok);
        check(ok, 1'b1);
        tclk_run = 1'b0;
        host.access(1'b1, 3'h0, 8'h40, q, f);
        host.wait_idle(ok);
        check(ok, 1'b1);
        host.access(1'b1, 3'h2, 8'h3c, q, f);
        host.wait_idle(ok);
        check(ok, 1'b1);
        host.access(1'b1, 3'h1, 8'h03, q, f);
        host.access(1'b1, 3'h7, 8'h00, q, f);
        host.wait_idle(ok);
        check(ok, 1'b1);
        host.access(1'b1, 3'h7, 8'h00, q, f);
        check(q, 8'ha5);
        host.wait_idle(ok);
        check(ok, 1'b1);
        host.access(1'b1, 3'h6, 8'h00, q, f);
        check(q, 8'h3c);
    endtask : s_xfer

    task automatic s_misc;
        logic [7:0] q;
        logic [1:0] f;
        int low;
        int hi;
        logic ckp;
        low = 0;
        hi = 0;
        conv_byte = 8'h5a;
        agc_gain = 3'h5;
        irq_req = 1'b1;
        @(negedge clk);
        check({gain_24, gain_12, gain_6}, 3'h5);
        check(irq_n_oe, 1'b1);
        check(irq_n_o, 1'b0);
        irq_req = 1'b0;
        host.access(1'b1, 3'h0, 8'h00, q, f);
        ckp = clock_pin_o;
        for (int n = 0; n < 900; n++) begin
            @(negedge clk);
            check(clock_pin_o, !ckp);
            ckp = clock_pin_o;
            if (n < 256) begin
                hi += digital_out;
            end
            if (conv_enable_n === 1'b1) begin
                check(conv_clk_out, 1'b0);
            end else begin
                low++;
            end
        end
        check(8'(hi), 8'h80);
        check(low > 0, 1'b1);
        check(conv_sample, 8'h5a);
    endtask : s_misc

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #3_000_000;
        errors++;
        finish_test();
    end

    initial begin
        repeat (8) @(negedge clk);
        check(data_oe, 1'b0);
        check(wait_n_oe, 1'b0);
        check(clock_pin_oe, 1'b1);
        check(conv_enable_n, 1'b1);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        s_decode();
        s_xfer();
        s_misc();
        finish_test();
    end
endmodule : tb
`default_nettype wire
